//--- src/bcm_params.svh
`ifndef BCM_PARAMS_SVH
`define BCM_PARAMS_SVH
// ==========================================================
// timing
`define BCM_CLK_MHZ          200
`define BCM_RESET_DELAY_US   10
`define BCM_RD_CYCLES        (`BCM_RESET_DELAY_US * `BCM_CLK_MHZ)
`define BCM_RD_CNT_W         12
`define BCM_CFG_FILTER_NS    500
`define BCM_CFG_F_CYCLES     ((`BCM_CFG_FILTER_NS * `BCM_CLK_MHZ + 999) / 1000)
`define BCM_CFG_F_CNT_W      8
// ==========================================================
// register offsets
`define BCM_ADDR_W           8
`define BCM_OFS_MODE_CTRL    8'h00
`define BCM_OFS_HW_CTRL      8'h04
`define BCM_OFS_STATUS       8'h08
`define BCM_OFS_WAKE_LVL     8'h0C
// ==========================================================
// fields
`define BCM_MODE_LSB         0
`define BCM_MODE_MSB         1
`define BCM_MODE_NORMAL      2'h0
`define BCM_MODE_STOP        2'h1
`define BCM_MODE_SLEEP       2'h2
`define BCM_MODE_SOFT_RST    2'h3
`define BCM_HW_SWCFG         0
`define BCM_HW_OVRST         1
`define BCM_HW_LOCK0         2
`define BCM_HW_LOCK1         3
`define BCM_ST_POR           0
`define BCM_ST_OV            1
`define BCM_ST_WARN          2
`define BCM_ST_UV            3
`define BCM_ST_VSUV          4
`define BCM_WL_PINCFG        0
`define BCM_WL_DEV           1
`define BCM_WL_STATE_LSB     2
`define BCM_WL_STATE_MSB     4
// ==========================================================
// soft reset values
`define BCM_SR_SWCFG         1'b0
`define BCM_SR_OVRST         1'b0
`define BCM_SR_LOCK0         1'b0
`endif

//--- src/bcm_pkg.sv
package bcm_pkg;
  typedef enum logic [2:0] {
    BCM_INIT, BCM_NORMAL, BCM_STOP, BCM_SLEEP, BCM_RESTART, BCM_FAILSAFE
  } bcm_mode_type;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
  } bcm_bus_req_type;
endpackage

//--- src/bcm_cfg_filter.sv
`timescale 1ns/1ps
`include "bcm_params.svh"
module bcm_cfg_filter (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic enable,
  input  wire logic level_in,
  output logic      filt_q
);
  logic                        cand_q;
  logic [`BCM_CFG_F_CNT_W-1:0] cnt_q;

  // ==========================================================
  // filter runs only while enable is high, keeps the last stable value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cand_q <= 1'b0;
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (enable) begin
      if (level_in != cand_q) begin
        cand_q <= level_in;
        cnt_q  <= '0;
      end else if (cnt_q == `BCM_CFG_F_CNT_W'(`BCM_CFG_F_CYCLES - 1)) begin
        filt_q <= cand_q;
      end else begin
        cnt_q <= cnt_q + `BCM_CFG_F_CNT_W'(1);
      end
    end
  end
endmodule

//--- src/bcm_ahb_slave.sv
`timescale 1ns/1ps
`include "bcm_params.svh"
module bcm_ahb_slave
  import bcm_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  input  wire logic [31:0]            rd_data,
  output logic [`BCM_ADDR_W-1:0]      rd_addr,
  output bcm_bus_req_type             req,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp
);
  logic                   accept;
  logic                   wpend_q;
  logic [`BCM_ADDR_W-1:0] waddr_q;

  // only word transfers are used; hsize is not decoded
  assign accept  = hsel && hready && htrans[1] && (hsize == hsize);
  assign rd_addr = haddr[`BCM_ADDR_W-1:0];
  assign req     = '{wr: wpend_q, addr: waddr_q, data: hwdata};

  // ==========================================================
  // zero wait state, read data fetched at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wpend_q   <= 1'b0;
      waddr_q   <= '0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wpend_q <= accept && hwrite;
      if (accept && hwrite) begin
        waddr_q <= haddr[`BCM_ADDR_W-1:0];
      end
      if (accept && !hwrite) begin
        hrdata <= rd_data;
      end
    end
  end
endmodule

//--- src/bcm_mode_ctrl.sv
`timescale 1ns/1ps
`include "bcm_params.svh"
module bcm_mode_ctrl
  import bcm_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        main_supply_good,
  input  wire logic        test_pin_high,
  input  wire logic        int_pin_level,
  input  wire logic        main_overvoltage,
  input  wire logic        main_supply_warning,
  input  wire logic        main_undervoltage,
  input  wire logic        battery_undervoltage,
  input  wire logic        bus_wake,
  input  wire logic        wake_sense_input,
  input  wire logic        gpio_wake,
  input  wire logic        overtemp,
  input  wire logic        spi_frame,
  input  wire logic        wd_fail,
  output logic             reset_output_low,
  output logic             int_pull_down_en,
  output logic             fail_output,
  output logic             main_supply_en,
  output logic             secondary_supply_en,
  output logic             can_force_normal,
  output logic             wd_halt,
  output logic             wd_long_window
);
  localparam int NSYNC = 11;

  logic [NSYNC-1:0]       s1_q, s2_q, s3_q;
  logic                   sup_ok, test_s, int_s, ov_s, warn_s, uv_s, vsuv_s;
  logic                   wake_rise, ot_fall, ov_rise;
  bcm_mode_type           mode_q, mode_d;
  logic [1:0]             mode_select_q;
  logic                   sw_cfg_q, ov_en_q, lock0_q, lock1_q;
  logic                   por_q, ov_flag_q, warn_q, uv_q, vsuv_q;
  logic                   pin_cfg_q, dev_q, wd_cnt_q, first_rel_q;
  logic                   cfg_filt, rst_low_d, rd_done, rel;
  logic [`BCM_RD_CNT_W-1:0] rd_cnt_q;
  logic                   wd_evt, ov_evt, ov_act, go_fs, go_rs, fo_set;
  logic                   frame_go, wake_evt, soft_wr, mode_wr;
  logic                   hw_wr, st_wr;
  logic [`BCM_ADDR_W-1:0] rd_addr;
  logic [31:0]            rd_data;
  bcm_bus_req_type        req;

  // ==========================================================
  // bus slave
  bcm_ahb_slave u_bus (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hready),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .req       (req),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp)
  );

  // ==========================================================
  // pin synchronisers, third stage only for edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= {overtemp, gpio_wake, wake_sense_input, bus_wake,
               battery_undervoltage, main_undervoltage,
               main_supply_warning, main_overvoltage, int_pin_level,
               test_pin_high, main_supply_good};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign {vsuv_s, uv_s, warn_s, ov_s, int_s, test_s, sup_ok} = s2_q[6:0];
  assign ov_rise   = s2_q[3] && !s3_q[3];
  assign ot_fall   = !s2_q[10] && s3_q[10];
  assign wake_rise = |(s2_q[9:7] & ~s3_q[9:7]);

  // ==========================================================
  // configuration pin filter
  bcm_cfg_filter u_filt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (int_pull_down_en),
    .level_in (int_s),
    .filt_q   (cfg_filt)
  );

  // ==========================================================
  // event decode
  assign soft_wr = req.wr && req.addr == `BCM_OFS_MODE_CTRL
                   && req.data[`BCM_MODE_MSB:`BCM_MODE_LSB]
                      == `BCM_MODE_SOFT_RST;
  assign mode_wr = req.wr && req.addr == `BCM_OFS_MODE_CTRL;
  assign hw_wr   = req.wr && req.addr == `BCM_OFS_HW_CTRL;
  assign st_wr   = req.wr && req.addr == `BCM_OFS_STATUS;
  assign wake_evt = wake_rise && mode_q != BCM_INIT;
  assign frame_go = (spi_frame || req.wr) && !reset_output_low;
  assign wd_evt  = wd_fail && !dev_q && !reset_output_low
                   && (mode_q == BCM_INIT || mode_q == BCM_NORMAL
                       || mode_q == BCM_STOP);
  assign ov_act  = mode_q != BCM_SLEEP && mode_q != BCM_FAILSAFE;
  assign ov_evt  = ov_rise && ov_act;
  assign go_fs   = (wd_evt && !pin_cfg_q && (sw_cfg_q || wd_cnt_q))
                   || (ov_evt && ov_en_q && !pin_cfg_q);
  assign go_rs   = (wd_evt || (ov_evt && ov_en_q)) && !go_fs;
  assign fo_set  = (wd_evt && (sw_cfg_q || wd_cnt_q))
                   || (ov_evt && ov_en_q);
  assign rd_done = rd_cnt_q == `BCM_RD_CNT_W'(`BCM_RD_CYCLES - 1);
  assign rel     = reset_output_low && !rst_low_d;

  // ==========================================================
  // mode state machine
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      BCM_INIT: begin
        if (frame_go) begin
          mode_d = BCM_NORMAL;
        end
      end
      BCM_NORMAL, BCM_STOP: begin
        if (mode_wr) begin
          unique case (req.data[`BCM_MODE_MSB:`BCM_MODE_LSB])
            `BCM_MODE_NORMAL: mode_d = BCM_NORMAL;
            `BCM_MODE_STOP:   mode_d = BCM_STOP;
            `BCM_MODE_SLEEP:  mode_d = BCM_SLEEP;
            default:          mode_d = mode_q;
          endcase
        end
      end
      BCM_SLEEP: begin
        if (wake_evt) begin
          mode_d = BCM_RESTART;
        end
      end
      BCM_RESTART: begin
        if (rd_done) begin
          mode_d = BCM_NORMAL;
        end
      end
      BCM_FAILSAFE: begin
        if (wake_evt || ot_fall) begin
          mode_d = BCM_RESTART;
        end
      end
    endcase
    if (go_fs) begin
      mode_d = BCM_FAILSAFE;
    end else if (go_rs) begin
      mode_d = BCM_RESTART;
    end
    if (soft_wr) begin
      mode_d = BCM_INIT;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_q <= BCM_INIT;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ==========================================================
  // reset output and reset delay
  always_comb begin
    rst_low_d = reset_output_low;
    if (rd_done) begin
      rst_low_d = 1'b0;
    end
    if (mode_d != mode_q && (mode_d == BCM_RESTART
        || mode_d == BCM_SLEEP || mode_d == BCM_FAILSAFE)) begin
      rst_low_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_cnt_q         <= '0;
      reset_output_low <= 1'b1;
      int_pull_down_en <= 1'b1;
      wd_long_window   <= 1'b0;
      first_rel_q      <= 1'b1;
    end else begin
      if (reset_output_low && sup_ok && !ov_s && !rd_done
          && (mode_q == BCM_INIT || mode_q == BCM_RESTART)) begin
        rd_cnt_q <= rd_cnt_q + `BCM_RD_CNT_W'(1);
      end else begin
        rd_cnt_q <= '0;
      end
      reset_output_low <= rst_low_d;
      int_pull_down_en <= rst_low_d && por_q;
      wd_long_window   <= rel;
      if (rel) begin
        first_rel_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // latched configuration and development mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_cfg_q <= 1'b0;
      dev_q     <= 1'b0;
    end else begin
      if (rel && por_q) begin
        pin_cfg_q <= cfg_filt;
      end
      if (mode_q == BCM_INIT) begin
        dev_q <= test_s;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_halt             <= 1'b0;
      can_force_normal    <= 1'b0;
      secondary_supply_en <= 1'b0;
      main_supply_en      <= 1'b1;
    end else begin
      wd_halt             <= dev_q;
      can_force_normal    <= dev_q;
      secondary_supply_en <= dev_q;
      main_supply_en      <= mode_d != BCM_FAILSAFE
                             && mode_d != BCM_SLEEP;
    end
  end

  // ==========================================================
  // failure tracking and fail output
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_q    <= 1'b0;
      fail_output <= 1'b0;
    end else if (soft_wr) begin
      wd_cnt_q    <= 1'b0;
      fail_output <= 1'b0;
    end else begin
      if (wd_evt) begin
        wd_cnt_q <= 1'b1;
      end
      if (fo_set) begin
        fail_output <= 1'b1;
      end
    end
  end

  // ==========================================================
  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_select_q <= `BCM_MODE_NORMAL;
    end else if (mode_q == BCM_RESTART || soft_wr) begin
      mode_select_q <= `BCM_MODE_NORMAL;
    end else if (mode_wr) begin
      mode_select_q <= req.data[`BCM_MODE_MSB:`BCM_MODE_LSB];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_cfg_q <= `BCM_SR_SWCFG;
      ov_en_q  <= `BCM_SR_OVRST;
      lock0_q  <= `BCM_SR_LOCK0;
      lock1_q  <= 1'b0;
    end else if (soft_wr) begin
      if (!(lock0_q || lock1_q)) begin
        sw_cfg_q <= `BCM_SR_SWCFG;
        ov_en_q  <= `BCM_SR_OVRST;
      end
      if (!lock1_q) begin
        lock0_q <= `BCM_SR_LOCK0;
      end
    end else if (hw_wr) begin
      if (!lock1_q) begin
        sw_cfg_q <= req.data[`BCM_HW_SWCFG];
        ov_en_q  <= req.data[`BCM_HW_OVRST];
      end
      lock0_q <= req.data[`BCM_HW_LOCK0];
      lock1_q <= lock1_q || req.data[`BCM_HW_LOCK1];
    end
  end

  // status flags: write one to clear, a new set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_q     <= 1'b1;
      ov_flag_q <= 1'b0;
      warn_q    <= 1'b0;
      uv_q      <= 1'b0;
      vsuv_q    <= 1'b0;
    end else begin
      por_q     <= por_q && !(st_wr && req.data[`BCM_ST_POR]);
      ov_flag_q <= ov_evt
                   || (ov_flag_q && !(st_wr && req.data[`BCM_ST_OV]));
      if (!first_rel_q || rel) begin
        warn_q <= warn_s
                  || (warn_q && !(st_wr && req.data[`BCM_ST_WARN]));
        uv_q   <= (uv_s && !reset_output_low)
                  || (uv_q && !(st_wr && req.data[`BCM_ST_UV]));
        vsuv_q <= vsuv_s
                  || (vsuv_q && !(st_wr && req.data[`BCM_ST_VSUV]));
      end
    end
  end

  // ==========================================================
  // read mux, unmapped reads return zero
  always_comb begin
    rd_data = 32'h0;
    unique case (rd_addr)
      `BCM_OFS_MODE_CTRL: begin
        rd_data[`BCM_MODE_MSB:`BCM_MODE_LSB] = mode_select_q;
      end
      `BCM_OFS_HW_CTRL: begin
        rd_data[`BCM_HW_SWCFG] = sw_cfg_q;
        rd_data[`BCM_HW_OVRST] = ov_en_q;
        rd_data[`BCM_HW_LOCK0] = lock0_q;
        rd_data[`BCM_HW_LOCK1] = lock1_q;
      end
      `BCM_OFS_STATUS: begin
        rd_data[`BCM_ST_POR]  = por_q;
        rd_data[`BCM_ST_OV]   = ov_flag_q;
        rd_data[`BCM_ST_WARN] = warn_q;
        rd_data[`BCM_ST_UV]   = uv_q;
        rd_data[`BCM_ST_VSUV] = vsuv_q;
      end
      `BCM_OFS_WAKE_LVL: begin
        rd_data[`BCM_WL_PINCFG] = pin_cfg_q;
        rd_data[`BCM_WL_DEV]    = dev_q;
        rd_data[`BCM_WL_STATE_MSB:`BCM_WL_STATE_LSB] = mode_q;
      end
      default: rd_data = 32'h0;
    endcase
  end

  // ==========================================================
  // checks
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_release;
    $fell(reset_output_low);
  endsequence

  sequence s_fs_fault;
    wd_evt && !pin_cfg_q && sw_cfg_q && !soft_wr;
  endsequence

  a_sel_cleared: assert property (mode_q == BCM_RESTART |=>
    mode_select_q == `BCM_MODE_NORMAL) else $error("mode select kept");
  a_restart_rst: assert property (mode_q == BCM_RESTART && !rd_done
    |=> reset_output_low) else $error("reset not held in restart");
  a_restart_out: assert property (mode_q == BCM_RESTART && rd_done
    && !go_fs && !go_rs && !soft_wr |=> mode_q == BCM_NORMAL
    && !reset_output_low) else $error("restart did not end");
  a_fs_supply: assert property (mode_q == BCM_FAILSAFE
    |-> !main_supply_en) else $error("supply on in fail-safe");
  a_cfg_latch: assert property (s_release ##0 $past(por_q)
    |-> pin_cfg_q == $past(cfg_filt)) else $error("config not latched");
  a_pd_release: assert property (s_release
    |-> ##1 !int_pull_down_en) else $error("pull-down left on");
  a_wd_failsafe: assert property (s_fs_fault
    |=> mode_q == BCM_FAILSAFE && fail_output)
    else $error("watchdog fail-safe missed");
  a_ov_flag: assert property (ov_evt |=> ov_flag_q
    ) else $error("overvoltage flag lost");
  a_ov_quiet: assert property (ov_evt && !ov_en_q && !wd_evt
    && !soft_wr |=> $stable(fail_output) && mode_q != BCM_FAILSAFE
    && (mode_q != BCM_RESTART || $past(mode_q) == BCM_RESTART))
    else $error("overvoltage acted while disabled");
  a_init_exit: assert property (mode_q == BCM_INIT && spi_frame
    && !reset_output_low && !soft_wr && !go_fs && !go_rs
    |=> mode_q == BCM_NORMAL) else $error("init not left");
  a_dev_halt: assert property (dev_q |=> wd_halt &&
    secondary_supply_en && can_force_normal) else $error("dev mode");
  a_soft_rst: assert property (soft_wr |=> mode_q == BCM_INIT
    ) else $error("soft reset missed");
endmodule

//--- testbench/bcm_mcu_model.sv
`timescale 1ns/1ps
module bcm_mcu_model (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic reset_output_low,
  input  wire logic frame_req,
  input  wire logic miss_req,
  output logic      spi_frame,
  output logic      wd_fail
);
  // ==========================================================
  // micro acts only while its reset is released
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spi_frame <= 1'b0;
      wd_fail   <= 1'b0;
    end else begin
      spi_frame <= frame_req & ~reset_output_low;
      // skipped service shows as a failure pulse
      wd_fail   <= miss_req & ~reset_output_low;
    end
  end
endmodule

//--- testbench/basis_chip_mode_control_tb_top.sv
`timescale 1ns/1ps
module basis_chip_mode_control_tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] d;
  logic        hreadyout, hresp, spi_frame, wd_fail;
  logic        pin = 1'b1, tst = 1'b0, ovr = 1'b0, warn = 1'b1;
  logic        bwk = 1'b0, wsk = 1'b0, fr_req = 1'b0, ms_req = 1'b0;
  logic        ot = 1'b0;
  logic        rst_lo, pd_en, fo, msup, ssup, canf, wdh, lw;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n;

  always #2.5 hclk = ~hclk;

  bcm_mode_ctrl uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .main_supply_good(1'b1), .test_pin_high(tst),
    .int_pin_level(pin), .main_overvoltage(ovr),
    .main_supply_warning(warn), .main_undervoltage(1'b0),
    .battery_undervoltage(1'b0), .bus_wake(bwk),
    .wake_sense_input(wsk), .gpio_wake(1'b0), .overtemp(ot),
    .spi_frame(spi_frame), .wd_fail(wd_fail),
    .reset_output_low(rst_lo), .int_pull_down_en(pd_en),
    .fail_output(fo), .main_supply_en(msup),
    .secondary_supply_en(ssup), .can_force_normal(canf),
    .wd_halt(wdh), .wd_long_window(lw)
  );

  bcm_mcu_model mcu_m (
    .hclk(hclk), .hresetn(hresetn), .reset_output_low(rst_lo),
    .frame_req(fr_req), .miss_req(ms_req),
    .spi_frame(spi_frame), .wd_fail(wd_fail)
  );

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask

  task automatic ms(input string nm, input logic [2:0] e);
    bus(1'b0, 8'h0C, 32'h0);
    chk(nm, {29'h0, d[4:2]}, {29'h0, e});
    chk("resp", hresp, 1'b0);
  endtask

  task automatic mcu(input logic f);
    @(posedge hclk);
    fr_req <= f;
    ms_req <= ~f;
    @(posedge hclk);
    fr_req <= 1'b0;
    ms_req <= 1'b0;
    cyc(3);
  endtask

  task automatic rel();
    n = 0;
    while (rst_lo !== 1'b0) begin
      @(negedge hclk);
      n++;
    end
  endtask

  // ==========================================================
  // scenarios
  task automatic pu(input logic p, input logic t);
    hresetn <= 1'b0;
    pin <= p;
    tst <= t;
    cyc(6);
    hresetn <= 1'b1;
    cyc(3);
    ms("init", 3'h0);
    bus(1'b0, 8'h08, 32'h0);
    chk("flags_early", d[4:0], 5'h01);
    chk("pull_down", pd_en, 1'b1);
    rel();
    chk("rd_time", n >= 1900, 1'b1);
    chk("long_win", lw, 1'b1);
    chk("pull_off", pd_en, 1'b0);
    bus(1'b0, 8'h0C, 32'h0);
    chk("cfg_dev", d[1:0], {t, p});
    bus(1'b0, 8'h08, 32'h0);
    chk("flags_late", d[2], 1'b1);
  endtask

  task automatic two_fail(input logic p);
    pu(p, 1'b0);
    mcu(1'b1);
    mcu(1'b0);
    ms("fail1", 3'h4);
    chk("fo1", fo, 1'b0);
    rel();
    mcu(1'b0);
    ms("fail2", p ? 3'h4 : 3'h5);
    chk("fo2", fo, 1'b1);
  endtask

  task automatic ov_pulse();
    ovr <= 1'b1;
    cyc(5);
    ovr <= 1'b0;
    cyc(5);
  endtask

  task automatic complete_run();
    if (miscompares == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    pu(1'b1, 1'b0);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", d, 32'h0);
    wsk <= 1'b1;
    cyc(5);
    wsk <= 1'b0;
    ms("wake_init", 3'h0);
    mcu(1'b1);
    ms("frame", 3'h1);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk("hw_ctrl", d[3:0], 4'h1);
    pin <= 1'b0;
    cyc(120);
    ov_pulse();
    ms("ov_off", 3'h1);
    bus(1'b0, 8'h08, 32'h0);
    chk("ov_flag", d[1], 1'b1);
    chk("fo_ov_off", fo, 1'b0);
    bus(1'b0, 8'h0C, 32'h0);
    chk("cfg_hold", d[0], 1'b1);
    bus(1'b1, 8'h04, 32'h3);
    bus(1'b1, 8'h00, 32'h1);
    ms("stop", 3'h2);
    ov_pulse();
    ms("ov_restart", 3'h4);
    chk("fo_ov", fo, 1'b1);
    chk("rst_on", rst_lo, 1'b1);
    chk("pd_again", pd_en, 1'b1);
    rel();
    ms("auto_normal", 3'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk("mode_clr", d[1:0], 2'h0);
    bus(1'b0, 8'h0C, 32'h0);
    chk("relatch", d[0], 1'b0);
    bus(1'b1, 8'h08, 32'h1);
    bus(1'b1, 8'h04, 32'h1);
    bus(1'b1, 8'h04, 32'h9);
    bus(1'b1, 8'h00, 32'h3);
    ms("soft_rst", 3'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk("locked", d[3:0], 4'h9);
    rel();
    mcu(1'b1);
    mcu(1'b0);
    ms("wd_failsafe", 3'h5);
    chk("fo_wd", fo, 1'b1);
    chk("supply_off", msup, 1'b0);
    bwk <= 1'b1;
    cyc(5);
    bwk <= 1'b0;
    ms("wake_exit", 3'h4);
    two_fail(1'b1);
    two_fail(1'b0);
    ot <= 1'b1;
    cyc(5);
    ot <= 1'b0;
    cyc(5);
    ms("ot_exit", 3'h4);
    pu(1'b1, 1'b1);
    chk("dev_outs", {wdh, ssup, canf}, 3'h7);
    mcu(1'b1);
    bus(1'b1, 8'h00, 32'h1);
    ms("dev_stop", 3'h2);
    complete_run();
  end

  initial begin
    cyc(40000);
    miscompares++;
    complete_run();
  end
endmodule
